// *** hdl/macrocell_config.sv ***
// Eight configurable output macrocells with preload, security and signature.
// Assumes the product-term array lies outside and feeds productTerm.
`timescale 1ns/100ps
module macrocell_config (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic registersAllowedBit,
  input wire logic emulationSelectBit,
  input wire logic [macrocell_pkg::NUM_CELLS-1:0] cellConfigBit,
  input wire logic [macrocell_pkg::NUM_CELLS-1:0] polarityBit,
  input wire logic [63:0] productTerm,
  input wire logic clockPin,
  input wire logic outputEnablePin_n,
  input wire logic [macrocell_pkg::NUM_CELLS-1:0] ioPinIn,
  output logic [macrocell_pkg::NUM_CELLS-1:0] ioPinOut,
  output logic [macrocell_pkg::NUM_CELLS-1:0] ioPinOe,
  output logic [macrocell_pkg::NUM_CELLS-1:0] arrayFeedback,
  input wire logic preloadEn,
  input wire logic securityProgram,
  input wire logic eraseCycle,
  output logic securityBit,
  input wire logic readbackReq,
  output logic readbackValid,
  output logic readbackDenied,
  output logic [macrocell_pkg::CFG_WIDTH-1:0] readbackData,
  input wire logic sigWrEn,
  input wire logic [macrocell_pkg::SIG_AW-1:0] sigWrAddr,
  input wire logic [macrocell_pkg::SIG_WIDTH-1:0] sigWrData,
  input wire logic [macrocell_pkg::SIG_AW-1:0] sigRdAddr,
  output logic [macrocell_pkg::SIG_WIDTH-1:0] sigRdData
);
  import macrocell_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when stages two and three
  // agree, so a single-cycle glitch never reaches the cells.
  logic [PIN_COUNT-1:0] syncA;
  logic [PIN_COUNT-1:0] syncB;
  logic [PIN_COUNT-1:0] syncC;
  logic [PIN_COUNT-1:0] pinFilt;
  logic [PIN_COUNT-1:0] next_pinFilt;
  logic clkPrev;
  logic next_clkPrev;
  logic [NUM_CELLS-1:0] ioFilt;
  logic clkFilt;
  logic oeFilt_n;
  logic clkRise;

  always_comb begin
    next_pinFilt = (~(syncB ^ syncC) & syncC) | ((syncB ^ syncC) & pinFilt);
    next_clkPrev = pinFilt[PIN_COUNT-1];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA <= PIN_RESET;
      syncB <= PIN_RESET;
      syncC <= PIN_RESET;
      pinFilt <= PIN_RESET;
      clkPrev <= 1'b0;
    end else begin
      syncA <= {clockPin, outputEnablePin_n, ioPinIn};
      syncB <= syncA;
      syncC <= syncB;
      pinFilt <= next_pinFilt;
      clkPrev <= next_clkPrev;
    end
  end

  assign ioFilt = pinFilt[NUM_CELLS-1:0];
  assign oeFilt_n = pinFilt[NUM_CELLS];
  assign clkFilt = pinFilt[PIN_COUNT-1];
  assign clkRise = clkFilt & ~clkPrev;

  ////////////////////////////////////////////////////////////////////////
  // Cell datapath: mode decode, sum, enable and feedback select
  cell_mode_e cellMode [NUM_CELLS];
  logic [NUM_CELLS-1:0] regQ;
  logic [NUM_CELLS-1:0] regD;
  logic [NUM_CELLS-1:0] next_regQ;

  always_comb begin
    logic sum8;
    logic sum7;
    logic enTerm;
    sum8 = 1'b0;
    sum7 = 1'b0;
    enTerm = 1'b0;
    for (int c = 0; c < NUM_CELLS; c++) begin
      cellMode[c] = decode_mode(registersAllowedBit, emulationSelectBit,
                                cellConfigBit[c]);
      sum8 = |productTerm[c*NUM_TERMS +: NUM_TERMS];
      sum7 = |productTerm[c*NUM_TERMS+1 +: NUM_TERMS-1];
      enTerm = productTerm[c*NUM_TERMS];
      regD[c] = sum8 ^ polarityBit[c]; // see RULE14 see RULE18
      case (cellMode[c])
        MODE_REG: begin
          ioPinOut[c] = ~regQ[c]; // see RULE6
          ioPinOe[c] = ~oeFilt_n; // see RULE14
          arrayFeedback[c] = regQ[c];
        end
        MODE_CIO_REG: begin
          ioPinOut[c] = ~(sum7 ^ polarityBit[c]); // see RULE1 see RULE2
          ioPinOe[c] = enTerm; // see RULE2
          arrayFeedback[c] = ioFilt[c]; // see RULE3
        end
        MODE_COMB_OUT: begin
          ioPinOut[c] = ~(sum8 ^ polarityBit[c]); // see RULE15 see RULE7
          ioPinOe[c] = 1'b1;
          // Outer cells lose their feedback here
          arrayFeedback[c] = is_outer(3'(c)) ? 1'b0 : ioPinOut[c]; // see RULE4
        end
        MODE_DED_IN: begin
          ioPinOut[c] = 1'b0;
          ioPinOe[c] = 1'b0; // see RULE16
          arrayFeedback[c] = ioFilt[adjacent_cell(3'(c))]; // see RULE16
        end
        MODE_CIO_COMB: begin
          ioPinOut[c] = ~(sum7 ^ polarityBit[c]); // see RULE17 see RULE7
          ioPinOe[c] = enTerm; // see RULE17
          arrayFeedback[c] = ioFilt[c];
        end
        default: begin
          ioPinOut[c] = 1'b0;
          ioPinOe[c] = 1'b0;
          arrayFeedback[c] = 1'b0;
        end
      endcase
    end
  end

  // Preload beats the clock pin so a tester can park any state, legal or not
  always_comb begin
    next_regQ = regQ;
    if (preloadEn) begin
      next_regQ = ~ioFilt; // see RULE8
    end else if (clkRise) begin
      for (int c = 0; c < NUM_CELLS; c++) begin
        if (cellMode[c] == MODE_REG) begin
          next_regQ[c] = regD[c]; // see RULE14
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regQ <= REG_RESET; // see RULE5
    end else begin
      regQ <= next_regQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Security bit and configuration readback
  logic next_securityBit;
  logic next_readbackValid;
  logic next_readbackDenied;
  logic [CFG_WIDTH-1:0] next_readbackData;
  logic [CFG_WIDTH-1:0] cfgWord;

  always_comb begin
    cfgWord = CFG_CLEAR;
    cfgWord[CFG_SG0_POS] = registersAllowedBit;
    cfgWord[CFG_SG1_POS] = emulationSelectBit;
    cfgWord[CFG_SL0_LSB +: NUM_CELLS] = cellConfigBit;
    cfgWord[CFG_SL1_LSB +: NUM_CELLS] = polarityBit;
    // Program in the erase cycle re-arms the bit: erase comes first
    if (securityProgram) begin
      next_securityBit = 1'b1;
    end else if (eraseCycle) begin
      next_securityBit = 1'b0; // see RULE10
    end else begin
      next_securityBit = securityBit;
    end
    next_readbackValid = readbackReq & ~securityBit; // see RULE9
    next_readbackDenied = readbackReq & securityBit; // see RULE9
    next_readbackData = next_readbackValid ? cfgWord : CFG_CLEAR;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      securityBit <= SEC_RESET;
      readbackValid <= 1'b0;
      readbackDenied <= 1'b0;
      readbackData <= CFG_CLEAR;
    end else begin
      securityBit <= next_securityBit;
      readbackValid <= next_readbackValid;
      readbackDenied <= next_readbackDenied;
      readbackData <= next_readbackData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Signature store, reachable whatever the security bit says
  sig_mem_if sigBus();

  assign sigBus.wrEn = sigWrEn;
  assign sigBus.wrAddr = sigWrAddr;
  assign sigBus.wrData = sigWrData;
  assign sigBus.rdAddr = sigRdAddr;
  assign sigRdData = sigBus.rdData; // see RULE12

  signature_mem u_sig (
    .sys_clk(sys_clk),
    .rst(rst),
    .port(sigBus.store)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_clear;
    disable iff (1'b0) rst |=> (regQ == REG_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // see RULE5
    else $error("register not cleared by reset");

  property p_preload;
    preloadEn |=> (regQ == ~$past(ioFilt));
  endproperty
  a_preload: assert property (p_preload) // see RULE8
    else $error("preload did not load pin state");

  property p_secure_refuse;
    (readbackReq && securityBit) |=> (readbackDenied && !readbackValid);
  endproperty
  a_secure_refuse: assert property (p_secure_refuse) // see RULE9
    else $error("readback served while secured");

  property p_secure_hold;
    (securityBit && !eraseCycle) |=> securityBit;
  endproperty
  a_secure_hold: assert property (p_secure_hold) // see RULE10
    else $error("security bit cleared without erase");

  property p_sig_read;
    (sigWrEn && sigRdAddr == sigWrAddr) ##1 (sigRdAddr == $past(sigRdAddr))
      |=> (sigRdData == $past(sigWrData, 2));
  endproperty
  a_sig_read: assert property (p_sig_read) // see RULE12
    else $error("signature read lost written byte");

  for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
    localparam int B = g * NUM_TERMS;

    property p_cio_reg;
      (cellMode[g] == MODE_CIO_REG) |-> (ioPinOe[g] == productTerm[B]) &&
        (ioPinOut[g] == ~((|productTerm[B+1 +: 7]) ^ polarityBit[g]));
    endproperty
    a_cio_reg: assert property (p_cio_reg) // see RULE2
      else $error("registered-device I/O term use wrong");

    property p_cio_fb;
      (cellMode[g] == MODE_CIO_REG) |-> (arrayFeedback[g] == ioFilt[g]);
    endproperty
    a_cio_fb: assert property (p_cio_fb) // see RULE3
      else $error("registered-device I/O feedback wrong");

    property p_outer_fb;
      (is_outer(3'(g)) && cellMode[g] == MODE_COMB_OUT) |-> !arrayFeedback[g];
    endproperty
    a_outer_fb: assert property (p_outer_fb) // see RULE4
      else $error("outer cell gave feedback");

    property p_pwr_high;
      disable iff (1'b0)
      rst ##1 (cellMode[g] == MODE_REG) |-> ioPinOut[g];
    endproperty
    a_pwr_high: assert property (p_pwr_high) // see RULE6
      else $error("registered pin not high after reset");

    property p_reg_load;
      (clkRise && !preloadEn && cellMode[g] == MODE_REG) |=>
        (regQ[g] == $past((|productTerm[B +: 8]) ^ polarityBit[g]));
    endproperty
    a_reg_load: assert property (p_reg_load) // see RULE14
      else $error("register did not load sum xor polarity");

    property p_comb_out;
      (cellMode[g] == MODE_COMB_OUT) |-> ioPinOe[g] &&
        (ioPinOut[g] == ~((|productTerm[B +: 8]) ^ polarityBit[g]));
    endproperty
    a_comb_out: assert property (p_comb_out) // see RULE15
      else $error("combinatorial output wrong");

    property p_ded_in;
      (cellMode[g] == MODE_DED_IN) |-> !ioPinOe[g] &&
        (arrayFeedback[g] == ioFilt[adjacent_cell(3'(g))]);
    endproperty
    a_ded_in: assert property (p_ded_in) // see RULE16
      else $error("dedicated input drives or feeds wrong pin");

    property p_cio_comb;
      (cellMode[g] == MODE_CIO_COMB) |-> (ioPinOe[g] == productTerm[B]);
    endproperty
    a_cio_comb: assert property (p_cio_comb) // see RULE17
      else $error("combinatorial I/O enable term wrong");
  end

  c_preload: cover property (preloadEn ##1 !preloadEn);
  c_reg_edge: cover property (clkRise && cellMode[0] == MODE_REG);
  c_denied: cover property (readbackReq && securityBit);
  c_erase: cover property (securityBit ##1 eraseCycle ##1 !securityBit);

endmodule

// *** pkg/macrocell_pkg.sv ***
// Constants, mode encoding and decode helpers for the output macrocells.
// Assumes one system clock; all configuration bits arrive as plain levels.
//
// Overview of operation
// RULE1 - Registers-off, emulation on, cell set: registered I/O
// RULE2 - Registered I/O: seven sum terms, one enable
// RULE3 - Registered I/O feeds back its own pin
// RULE4 - Outer cells give no feedback as outputs
// RULE5 - Power-up clears every flip-flop low
// RULE6 - Registered pins read high after power-up
// RULE7 - Combinatorial pins show logic after power-up
// RULE8 - Registers preload from pins, illegal states included
// RULE9 - Security bit blocks array readback and verify
// RULE10 - Only whole-array erase clears security bit; here reset also clears it to SEC_RESET
// RULE11 - Hold a 64-bit user signature
// RULE12 - Signature readable regardless of security bit
// RULE13 - Programmer erases automatically while programming
// RULE14 - Registered: D is sum xor polarity, pin enable
// RULE15 - Registers-on, emulation off, cell clear: output
// RULE16 - Dedicated input: buffer off, neighbour pin feedback
// RULE17 - All bits set: seven terms plus enable term
// RULE18 - Each cell polarity selected by its own bit

package macrocell_pkg;

  localparam int NUM_CELLS = 8;
  localparam int NUM_TERMS = 8;
  localparam int SIG_BITS = 64;
  localparam int SIG_WIDTH = 8;
  localparam int SIG_WORDS = SIG_BITS / SIG_WIDTH;
  localparam int SIG_AW = 3;
  localparam int PIN_COUNT = NUM_CELLS + 2;
  localparam int CFG_WIDTH = 18;
  localparam int CFG_SG0_POS = 17;
  localparam int CFG_SG1_POS = 16;
  localparam int CFG_SL0_LSB = 8;
  localparam int CFG_SL1_LSB = 0;
  localparam logic [NUM_CELLS-1:0] REG_RESET = 8'h00;
  localparam logic SEC_RESET = 1'b0;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 10'h000;
  localparam logic [CFG_WIDTH-1:0] CFG_CLEAR = 18'h00000;
  localparam logic [SIG_WIDTH-1:0] SIG_CLEAR = 8'h00;
  localparam logic [2:0] OUTER_LOW = 3'h0;
  localparam logic [2:0] OUTER_HIGH = 3'h7;

  typedef enum logic [5:0] {
    MODE_REG      = 6'h01,
    MODE_CIO_REG  = 6'h02,
    MODE_COMB_OUT = 6'h04,
    MODE_DED_IN   = 6'h08,
    MODE_CIO_COMB = 6'h10,
    MODE_UNUSED   = 6'h20
  } cell_mode_e;

  function automatic cell_mode_e decode_mode(input logic sg0,
                                             input logic sg1,
                                             input logic sl0);
    cell_mode_e m;
    case ({sg0, sg1, sl0})
      3'h2: m = MODE_REG;
      3'h3: m = MODE_CIO_REG;
      3'h4: m = MODE_COMB_OUT;
      3'h5: m = MODE_DED_IN;
      3'h7: m = MODE_CIO_COMB;
      default: m = MODE_UNUSED;
    endcase
    return m;
  endfunction

  // Neighbour pin that a dedicated input borrows
  function automatic logic [2:0] adjacent_cell(input logic [2:0] i);
    return (i == OUTER_HIGH) ? 3'h6 : 3'(i + 3'h1);
  endfunction

  function automatic logic is_outer(input logic [2:0] i);
    return (i == OUTER_LOW) || (i == OUTER_HIGH);
  endfunction

endpackage

// *** pkg/sig_mem_if.sv ***
// Carrier between the macrocell top and its signature store.
// Assumes both ends sit on the same system clock.
`timescale 1ns/100ps
interface sig_mem_if;
  logic wrEn;
  logic [macrocell_pkg::SIG_AW-1:0] wrAddr;
  logic [macrocell_pkg::SIG_WIDTH-1:0] wrData;
  logic [macrocell_pkg::SIG_AW-1:0] rdAddr;
  logic [macrocell_pkg::SIG_WIDTH-1:0] rdData;
  modport owner(output wrEn, output wrAddr, output wrData, output rdAddr,
                input rdData);
  modport store(input wrEn, input wrAddr, input wrData, input rdAddr,
                output rdData);
endinterface

// *** hdl/signature_mem.sv ***
// Signature word store, eight bytes, registered read port.
// Assumes the owner keeps the write strobe to one cycle per byte.
`timescale 1ns/100ps
module signature_mem (
  input wire logic sys_clk,
  input wire logic rst,
  sig_mem_if.store port
);
  import macrocell_pkg::*;

  logic [SIG_WIDTH-1:0] words [SIG_WORDS];
  logic [SIG_WIDTH-1:0] rdData;
  logic [SIG_WIDTH-1:0] next_rdData;

  ////////////////////////////////////////////////////////////////////////
  // Contents are nonvolatile, so reset leaves them alone
  always_ff @(posedge sys_clk) begin
    if (port.wrEn) begin
      words[port.wrAddr] <= port.wrData; // see RULE11
    end
  end

  // No security gate on this path
  always_comb begin
    next_rdData = words[port.rdAddr]; // see RULE12
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData <= SIG_CLEAR;
    end else begin
      rdData <= next_rdData;
    end
  end

  assign port.rdData = rdData;

endmodule

// *** tb/board_model.sv ***
// Board and programmer model around the macrocells.
// Assumes the bench calls its tasks shortly after a sys_clk edge.
`timescale 1ns/100ps
module board_model (
  input wire logic sys_clk,
  input wire logic [macrocell_pkg::NUM_CELLS-1:0] ioPinOut,
  input wire logic [macrocell_pkg::NUM_CELLS-1:0] ioPinOe,
  output logic [macrocell_pkg::NUM_CELLS-1:0] ioPinIn,
  output logic clockPin,
  output logic eraseCycle,
  output logic securityProgram
);
  import macrocell_pkg::*;

  logic [NUM_CELLS-1:0] boardDrive;

  initial begin
    boardDrive = 8'h00;
    clockPin = 1'b0;
    eraseCycle = 1'b0;
    securityProgram = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Driven pins win, released pins follow the board; tester sets states
  assign ioPinIn = (ioPinOe & ioPinOut) | (~ioPinOe & boardDrive);

  task automatic drive_board(input logic [NUM_CELLS-1:0] v);
    boardDrive = v;
  endtask

  // Four cycles per level, so the pin filter cannot drop the pulse
  task automatic clock_edge();
    clockPin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    clockPin = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // Programming always starts with a whole-array erase
  task automatic program_device(input logic secure);
    eraseCycle = 1'b1;
    @(posedge sys_clk);
    #1;
    eraseCycle = 1'b0;
    securityProgram = secure;
    @(posedge sys_clk);
    #1;
    securityProgram = 1'b0;
  endtask
endmodule

// *** tb/macrocell_config_test.sv ***
// Self-checking bench for the macrocell block.
// Assumes the board model supplies pins, clock pin and programming pulses.
`timescale 1ns/100ps
module macrocell_config_test;
  import macrocell_pkg::*;

  localparam logic [63:0] TERMS = 64'h0181_0080_0302_0001;
  logic sys_clk, rst, registersAllowedBit, emulationSelectBit, clockPin;
  logic outputEnablePin_n, preloadEn, securityProgram, eraseCycle;
  logic readbackReq, readbackValid, readbackDenied, securityBit, sigWrEn;
  logic [NUM_CELLS-1:0] cellConfigBit, polarityBit, ioPinIn, ioPinOut;
  logic [NUM_CELLS-1:0] ioPinOe, arrayFeedback;
  logic [63:0] productTerm;
  logic [CFG_WIDTH-1:0] readbackData;
  logic [SIG_AW-1:0] sigWrAddr, sigRdAddr;
  logic [SIG_WIDTH-1:0] sigWrData, sigRdData;
  int errCount, checkCount, cycles;

  macrocell_config i_dut (.sys_clk, .rst, .registersAllowedBit,
    .emulationSelectBit, .cellConfigBit, .polarityBit, .productTerm,
    .clockPin, .outputEnablePin_n, .ioPinIn, .ioPinOut, .ioPinOe,
    .arrayFeedback, .preloadEn, .securityProgram, .eraseCycle, .securityBit,
    .readbackReq, .readbackValid, .readbackDenied, .readbackData, .sigWrEn,
    .sigWrAddr, .sigWrData, .sigRdAddr, .sigRdData);
  board_model i_board (.sys_clk, .ioPinOut, .ioPinOe, .ioPinIn, .clockPin,
    .eraseCycle, .securityProgram);

  always #25 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [63:0] got,
                       input logic [63:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] fn_out(input logic seven,
                                        input logic [7:0] pol);
    logic [7:0] r;
    for (int c = 0; c < NUM_CELLS; c++) begin
      r[c] = ~((seven ? |TERMS[c*8+1 +: 7] : |TERMS[c*8 +: 8]) ^ pol[c]);
    end
    return r;
  endfunction

  function automatic logic [7:0] fn_en();
    logic [7:0] r;
    for (int c = 0; c < NUM_CELLS; c++) begin
      r[c] = TERMS[c*8];
    end
    return r;
  endfunction

  task automatic set_mode(input logic g0, input logic g1,
                          input logic [7:0] l0);
    registersAllowedBit = g0;
    emulationSelectBit = g1;
    cellConfigBit = l0;
    step(6);
  endtask

  // Shared by both combinatorial I/O modes
  task automatic cio_check(input logic [7:0] board);
    logic [7:0] o;
    logic [7:0] e;
    o = fn_out(1'b1, polarityBit);
    e = fn_en();
    i_board.drive_board(board);
    step(6);
    check("cio out", ioPinOut, o);
    check("cio oe", ioPinOe, e);
    check("cio fb", arrayFeedback, (e & o) | (~e & board));
  endtask

  task automatic readback(input logic denied, input logic [17:0] exp);
    readbackReq = 1'b1;
    step(1);
    readbackReq = 1'b0;
    check("rb valid", readbackValid, !denied);
    check("rb denied", readbackDenied, denied);
    check("rb data", readbackData, exp);
    // Let an edge pass so a following request is a fresh strobe
    step(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    check("pu out", ioPinOut, {fn_out(1'b1, 8'h5a) >> 4, 4'hf});
    check("pu oe", ioPinOe, {fn_en() >> 4, 4'hf});
    $display("test powerup done");
  endtask

  task automatic t_reg_load();
    set_mode(1'b0, 1'b1, 8'h00);
    check("reg hold", ioPinOut, 8'hff);
    i_board.clock_edge();
    check("reg load", ioPinOut, fn_out(1'b0, 8'h5a));
    polarityBit = 8'ha5;
    step(2);
    check("reg no clk", ioPinOut, fn_out(1'b0, 8'h5a));
    i_board.clock_edge();
    check("reg pol", ioPinOut, fn_out(1'b0, 8'ha5));
    outputEnablePin_n = 1'b1;
    step(6);
    check("reg oe off", ioPinOe, 8'h00);
    $display("test register load done");
  endtask

  task automatic t_preload();
    i_board.drive_board(8'h96);
    step(5);
    preloadEn = 1'b1;
    step(1);
    preloadEn = 1'b0;
    outputEnablePin_n = 1'b0;
    step(6);
    check("preload", ioPinOut, 8'h96);
    check("preload oe", ioPinOe, 8'hff);
    $display("test preload done");
  endtask

  task automatic t_modes();
    set_mode(1'b0, 1'b1, 8'hff);
    cio_check(8'h3c);
    set_mode(1'b1, 1'b1, 8'hff);
    cio_check(8'hc3);
    set_mode(1'b1, 1'b0, 8'h00);
    check("co out", ioPinOut, fn_out(1'b0, polarityBit));
    check("co oe", ioPinOe, 8'hff);
    check("co outer fb", arrayFeedback & 8'h81, 8'h00);
    set_mode(1'b1, 1'b0, 8'hff);
    i_board.drive_board(8'h5c);
    step(6);
    check("in oe", ioPinOe, 8'h00);
    check("in fb", arrayFeedback, 8'hae);
    $display("test modes done");
  endtask

  task automatic t_secure_sig();
    logic [17:0] cfg;
    cfg = {registersAllowedBit, emulationSelectBit, cellConfigBit,
           polarityBit};
    readback(1'b0, cfg);
    i_board.program_device(1'b1);
    check("sec set", securityBit, 1'b1);
    readback(1'b1, 18'h00000);
    readback(1'b1, 18'h00000);
    for (int a = 0; a < SIG_WORDS; a++) begin
      sigWrEn = 1'b1;
      sigWrAddr = 3'(a);
      sigWrData = {3'(a), 2'h2, 3'(a)};
      step(1);
    end
    sigWrEn = 1'b0;
    for (int a = 0; a < SIG_WORDS; a++) begin
      sigRdAddr = 3'(a);
      step(1);
      check("sig", sigRdData, {3'(a), 2'h2, 3'(a)});
    end
    i_board.program_device(1'b0);
    check("sec clr", securityBit, 1'b0);
    readback(1'b0, cfg);
    $display("test security and signature done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run needs a little over a hundred cycles; ceiling is generous
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errCount++;
      $display("[FAIL] %0t run timed out", $time);
      finish_test();
    end
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    registersAllowedBit = 1'b0;
    emulationSelectBit = 1'b1;
    cellConfigBit = 8'hf0;
    polarityBit = 8'h5a;
    productTerm = TERMS;
    outputEnablePin_n = 1'b0;
    preloadEn = 1'b0;
    readbackReq = 1'b0;
    sigWrEn = 1'b0;
    sigWrAddr = 3'h0;
    sigWrData = 8'h00;
    sigRdAddr = 3'h0;
    errCount = 0;
    checkCount = 0;
    cycles = 0;
    t_powerup();
    t_reg_load();
    t_preload();
    t_modes();
    t_secure_sig();
    finish_test();
  end
endmodule
